// file: core/amc_core.sv
// asynchronous serial transceiver with multiprocessor addressing
// assumes control bits come straight from software-written flops on clk
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
module amc_core #(
  parameter int DIV_W = 8
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clkEn,
  input wire logic rxdPin,
  output logic txdPin,
  input wire logic sckPinIn,
  output logic sckPinOut,
  output logic sckPinOe,
  input wire logic syncMode,
  input wire logic clockEnableLow,
  input wire logic clockEnableHigh,
  input wire logic [DIV_W-1:0] baudDivisor,
  input wire logic characterLength,
  input wire logic parityEnable,
  input wire logic parityOdd,
  input wire logic multiprocFormatSelect,
  input wire logic stopLength,
  input wire logic transmitEnable,
  input wire logic receiveEnable,
  input wire logic transmitIrqEnable,
  input wire logic transmitEndIrqEnable,
  input wire logic receiveIrqEnable,
  input wire logic [7:0] txData,
  input wire logic txDataWrite,
  input wire logic transmitMultiprocBit,
  output logic [7:0] rxData,
  input wire logic receiveFullClear,
  input wire logic overrunClear,
  input wire logic framingErrorClear,
  input wire logic parityErrorClear,
  input wire logic addressWaitSet,
  output logic addressWaitEnable,
  output logic transmitBufferEmpty,
  output logic transmitEnd,
  output logic receiveFull,
  output logic overrunFlag,
  output logic framingErrorFlag,
  output logic parityErrorFlag,
  output logic receivedMultiprocBit,
  output logic transmitEmptyRequest,
  output logic transmitEndRequest,
  output logic receiveFullRequest,
  output logic receiveErrorRequest
);

  //////////////////////////////////////////////////////////////////////////////
  // pins and basic clock

  logic rxdSync;
  logic sckSync;
  logic basicTick;
  logic sckDrive;

  amc_sync2 #(.WIDTH(2)) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .clkEn(clkEn),
    .pinIn({rxdPin, sckPinIn}),
    .pinSync({rxdSync, sckSync})
  );

  amc_clk_sel #(.DIV_W(DIV_W)) u_clk (
    .clk(clk),
    .arst_n(arst_n),
    .clkEn(clkEn),
    .syncMode(syncMode),
    .clockEnableLow(clockEnableLow),
    .clockEnableHigh(clockEnableHigh),
    .baudDivisor(baudDivisor),
    .sckSync(sckSync),
    .basicTick(basicTick),
    .sckDrive(sckDrive)
  );

  // frame shape shared by both directions
  logic [3:0] dataBits;
  logic hasExtra;
  logic useParity;
  assign dataBits = characterLength ? amc_pkg::BITS_SHORT : amc_pkg::BITS_LONG;
  assign useParity = parityEnable & ~multiprocFormatSelect;
  assign hasExtra = useParity | multiprocFormatSelect;

  //////////////////////////////////////////////////////////////////////////////
  // transmitter

  amc_pkg::amc_tx_state_e txState_q;
  logic [3:0] txPhase_q;
  logic [3:0] txBitCnt_q;
  logic [7:0] txShift_q;
  logic [7:0] txBuf_q;
  logic txExtra_q;
  logic txStop2_q;
  logic txNext_q;
  logic txBoundary;
  logic txLoad;
  logic txLoadParity;
  logic [7:0] txMasked;

  assign txBoundary = basicTick && (txPhase_q == amc_pkg::PHASE_LAST);
  assign txMasked = characterLength ? {1'b0, txBuf_q[6:0]} : txBuf_q;
  assign txLoadParity = (^txMasked) ^ parityOdd;
  // load from idle on a bit boundary, or at entry to the stop bit
  assign txLoad = transmitEnable && !transmitBufferEmpty && txBoundary &&
                  ((txState_q == amc_pkg::TX_IDLE) ||
                   (txState_q == amc_pkg::TX_EXTRA) ||
                   (txState_q == amc_pkg::TX_DATA && txBitCnt_q == dataBits && !hasExtra));

  // free-running phase keeps the output clock glitch-free
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      txPhase_q <= amc_pkg::PHASE_FIRST;
    end else if (basicTick) begin
      txPhase_q <= amc_pkg::PHASE_W'(txPhase_q + 1'b1);
    end
  end

  // bit rate clock, rising at phase eight, the centre of each bit
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sckPinOut <= 1'b1;
    end else if (clkEn) begin
      sckPinOut <= (txPhase_q >= amc_pkg::PHASE_SCK_RISE);
    end
  end
  assign sckPinOe = sckDrive;

  // buffer register, written only while empty
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      txBuf_q <= amc_pkg::DATA_RESET;
    end else if (clkEn && txDataWrite && transmitBufferEmpty && transmitEnable) begin
      txBuf_q <= txData;
    end
  end

  // empty flag: a write clears it, a load or disable sets it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      transmitBufferEmpty <= amc_pkg::TX_EMPTY_RESET;
    end else if (clkEn) begin
      if (!transmitEnable) begin
        transmitBufferEmpty <= 1'b1;
      end else if (txLoad) begin
        transmitBufferEmpty <= 1'b1;
      end else if (txDataWrite && transmitBufferEmpty) begin
        transmitBufferEmpty <= 1'b0;
      end
    end
  end

  // end flag: set when the stop bit finds nothing queued; set beats write
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      transmitEnd <= amc_pkg::TX_END_RESET;
    end else if (clkEn) begin
      if (!transmitEnable) begin
        transmitEnd <= 1'b1;
      end else if (txBoundary && transmitBufferEmpty &&
                   ((txState_q == amc_pkg::TX_EXTRA) ||
                    (txState_q == amc_pkg::TX_DATA && txBitCnt_q == dataBits &&
                     !hasExtra))) begin
        transmitEnd <= 1'b1;
      end else if (txDataWrite && transmitBufferEmpty) begin
        transmitEnd <= 1'b0;
      end
    end
  end

  // frame sequencer; a byte loaded at stop time starts right after it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      txState_q <= amc_pkg::TX_IDLE;
      txBitCnt_q <= amc_pkg::BIT_FIRST;
      txShift_q <= amc_pkg::DATA_RESET;
      txExtra_q <= 1'b0;
      txStop2_q <= 1'b0;
      txNext_q <= 1'b0;
    end else if (clkEn) begin
      if (txLoad) begin
        txShift_q <= txMasked;
        txExtra_q <= multiprocFormatSelect ? transmitMultiprocBit : txLoadParity;
      end
      if (!transmitEnable) begin
        txState_q <= amc_pkg::TX_IDLE;
        txNext_q <= 1'b0;
      end else if (txBoundary) begin
        case (txState_q)
          amc_pkg::TX_IDLE: begin
            if (txLoad) begin
              txState_q <= amc_pkg::TX_START;
            end
          end
          amc_pkg::TX_START: begin
            txBitCnt_q <= amc_pkg::BIT_FIRST;
            txState_q <= amc_pkg::TX_DATA;
          end
          amc_pkg::TX_DATA: begin
            if (txBitCnt_q == dataBits) begin
              txState_q <= hasExtra ? amc_pkg::TX_EXTRA : amc_pkg::TX_STOP;
              txStop2_q <= stopLength;
              txNext_q <= !hasExtra && !transmitBufferEmpty;
            end else begin
              txBitCnt_q <= 4'(txBitCnt_q + 1'b1);
              if (!txLoad) begin
                txShift_q <= {1'b0, txShift_q[7:1]};
              end
            end
          end
          amc_pkg::TX_EXTRA: begin
            txState_q <= amc_pkg::TX_STOP;
            txStop2_q <= stopLength;
            txNext_q <= !transmitBufferEmpty;
          end
          amc_pkg::TX_STOP: begin
            if (txStop2_q) begin
              txStop2_q <= 1'b0;
            end else begin
              txState_q <= txNext_q ? amc_pkg::TX_START : amc_pkg::TX_IDLE;
              txNext_q <= 1'b0;
            end
          end
          default: begin
            txState_q <= amc_pkg::TX_IDLE;
          end
        endcase
      end
    end
  end

  // line driver; the shifter bottom bit is the bit on the wire
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      txdPin <= amc_pkg::LINE_IDLE;
    end else if (clkEn) begin
      case (txState_q)
        amc_pkg::TX_START: txdPin <= amc_pkg::LINE_START;
        amc_pkg::TX_DATA: txdPin <= txShift_q[0];
        amc_pkg::TX_EXTRA: txdPin <= txExtra_q;
        default: txdPin <= amc_pkg::LINE_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // receiver

  amc_pkg::amc_rx_state_e rxState_q;
  logic [3:0] rxPhase_q;
  logic [3:0] rxBitCnt_q;
  logic [7:0] rxShift_q;
  logic rxParity_q;
  logic rxExtra_q;
  logic rxPrev_q;
  logic rxSample;
  logic rxErrorAny;
  logic rxDone;
  logic rxSkip;
  logic rxParityBad;
  logic rxStopBad;
  logic [7:0] rxAligned;

  assign rxSample = basicTick && (rxPhase_q == amc_pkg::PHASE_SAMPLE);
  assign rxErrorAny = overrunFlag | framingErrorFlag | parityErrorFlag;
  // a stop sample landing as receive is disabled must not touch flags or data
  assign rxDone = rxSample && (rxState_q == amc_pkg::RX_STOP) && receiveEnable;
  // data frames are invisible while waiting for an address
  assign rxSkip = multiprocFormatSelect && addressWaitEnable && !rxExtra_q;
  assign rxParityBad = useParity && (rxParity_q ^ rxExtra_q ^ parityOdd);
  assign rxStopBad = (rxdSync != amc_pkg::LINE_IDLE);
  assign rxAligned = characterLength ? {1'b0, rxShift_q[7:1]} : rxShift_q;

  // frame sequencer; only the first stop bit is checked
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rxState_q <= amc_pkg::RX_IDLE;
      rxPhase_q <= amc_pkg::PHASE_FIRST;
      rxBitCnt_q <= amc_pkg::BIT_FIRST;
      rxShift_q <= amc_pkg::DATA_RESET;
      rxParity_q <= 1'b0;
      rxExtra_q <= 1'b0;
      rxPrev_q <= amc_pkg::LINE_IDLE;
    end else if (clkEn) begin
      if (basicTick) begin
        rxPrev_q <= rxdSync;
        rxPhase_q <= amc_pkg::PHASE_W'(rxPhase_q + 1'b1);
      end
      if (!receiveEnable) begin
        rxState_q <= amc_pkg::RX_IDLE;
      end else if (basicTick) begin
        case (rxState_q)
          amc_pkg::RX_IDLE: begin
            // a new frame waits until software has cleared old errors
            if (rxPrev_q && !rxdSync && !rxErrorAny) begin
              rxState_q <= amc_pkg::RX_START;
              rxPhase_q <= amc_pkg::PHASE_FIRST;
            end
          end
          amc_pkg::RX_START: begin
            if (rxSample) begin
              // a glitch shorter than half a bit is not a start bit
              rxState_q <= rxdSync ? amc_pkg::RX_IDLE : amc_pkg::RX_DATA;
              rxBitCnt_q <= amc_pkg::BIT_FIRST;
              rxParity_q <= 1'b0;
              rxExtra_q <= 1'b0;
            end
          end
          amc_pkg::RX_DATA: begin
            if (rxSample) begin
              rxShift_q <= {rxdSync, rxShift_q[7:1]};
              rxParity_q <= rxParity_q ^ rxdSync;
              rxBitCnt_q <= 4'(rxBitCnt_q + 1'b1);
              if (rxBitCnt_q == dataBits) begin
                rxState_q <= hasExtra ? amc_pkg::RX_EXTRA : amc_pkg::RX_STOP;
              end
            end
          end
          amc_pkg::RX_EXTRA: begin
            if (rxSample) begin
              rxExtra_q <= rxdSync;
              rxState_q <= amc_pkg::RX_STOP;
            end
          end
          amc_pkg::RX_STOP: begin
            if (rxSample) begin
              rxState_q <= amc_pkg::RX_IDLE;
            end
          end
          default: begin
            rxState_q <= amc_pkg::RX_IDLE;
          end
        endcase
      end
    end
  end

  // receive data register; untouched on overrun or skipped frames
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rxData <= amc_pkg::DATA_RESET;
    end else if (clkEn && rxDone && !rxSkip && !receiveFull) begin
      rxData <= rxAligned;
    end
  end

  // full flag: only a clean frame sets it, and set beats clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      receiveFull <= 1'b0;
    end else if (clkEn) begin
      if (rxDone && !rxSkip && !receiveFull && !rxParityBad && !rxStopBad) begin
        receiveFull <= 1'b1;
      end else if (receiveFullClear) begin
        receiveFull <= 1'b0;
      end
    end
  end

  // error flags; each completion event beats its clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      overrunFlag <= 1'b0;
      framingErrorFlag <= 1'b0;
      parityErrorFlag <= 1'b0;
    end else if (clkEn) begin
      if (rxDone && !rxSkip && receiveFull) begin
        overrunFlag <= 1'b1;
      end else if (overrunClear) begin
        overrunFlag <= 1'b0;
      end
      if (rxDone && !rxSkip && rxStopBad) begin
        framingErrorFlag <= 1'b1;
      end else if (framingErrorClear) begin
        framingErrorFlag <= 1'b0;
      end
      if (rxDone && !rxSkip && rxParityBad) begin
        parityErrorFlag <= 1'b1;
      end else if (parityErrorClear) begin
        parityErrorFlag <= 1'b0;
      end
    end
  end

  // address wait: software sets it, an address frame ends it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      addressWaitEnable <= 1'b0;
      receivedMultiprocBit <= 1'b0;
    end else if (clkEn) begin
      if (rxDone && multiprocFormatSelect && !rxSkip) begin
        receivedMultiprocBit <= rxExtra_q;
      end
      if (rxDone && multiprocFormatSelect && rxExtra_q) begin
        addressWaitEnable <= 1'b0;
      end else if (addressWaitSet) begin
        addressWaitEnable <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // request lines, levels gated by their enables

  assign transmitEmptyRequest = transmitIrqEnable & transmitEnable & transmitBufferEmpty;
  assign transmitEndRequest = transmitEndIrqEnable & transmitEnd;
  assign receiveFullRequest = receiveIrqEnable & receiveFull;
  assign receiveErrorRequest = receiveIrqEnable & rxErrorAny;

endmodule

// file: core/amc_pkg.sv
// constants and state encodings for the asynchronous serial unit
// assumes a single system clock; serial timing is derived from a basic tick
package amc_pkg;

  // basic clock runs at sixteen ticks per bit
  localparam int unsigned OVERSAMPLE = 16;
  localparam int unsigned PHASE_W = 4;
  localparam logic [3:0] PHASE_FIRST = 4'h0;
  localparam logic [3:0] PHASE_SAMPLE = 4'h7;
  localparam logic [3:0] PHASE_LAST = 4'hF;
  localparam logic [3:0] PHASE_SCK_RISE = 4'h8;

  // data lengths selected by the character-length bit
  localparam logic [3:0] BITS_LONG = 4'h8;
  localparam logic [3:0] BITS_SHORT = 4'h7;
  localparam logic [3:0] BIT_FIRST = 4'h1;

  // reset values of flags and line
  localparam logic TX_EMPTY_RESET = 1'b1;
  localparam logic TX_END_RESET = 1'b1;
  localparam logic LINE_IDLE = 1'b1;
  localparam logic LINE_START = 1'b0;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // gray codes along start, data, extra, stop
  typedef enum logic [2:0] {
    TX_IDLE = 3'h0,
    TX_START = 3'h1,
    TX_DATA = 3'h3,
    TX_EXTRA = 3'h2,
    TX_STOP = 3'h6
  } amc_tx_state_e;

  typedef enum logic [2:0] {
    RX_IDLE = 3'h0,
    RX_START = 3'h1,
    RX_DATA = 3'h3,
    RX_EXTRA = 3'h2,
    RX_STOP = 3'h6
  } amc_rx_state_e;

endpackage

// file: core/amc_sync2.sv
// two-flop synchroniser for pins arriving from outside the clock domain
// assumes nothing about the source; first stage feeds only the second
`timescale 1ns/1ps
module amc_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clkEn,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] pinSync
);

  logic [WIDTH-1:0] meta_q;

  // both stages reset to idle-high, the mark level of the line
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= '1;
      pinSync <= '1;
    end else if (clkEn) begin
      meta_q <= pinIn;
      pinSync <= meta_q;
    end
  end

endmodule

// file: core/amc_clk_sel.sv
// basic clock source: internal divider or synchronised external serial clock
// assumes the external clock input is already synchronised to clk
`timescale 1ns/1ps
module amc_clk_sel #(
  parameter int DIV_W = 8
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clkEn,
  input wire logic syncMode,
  input wire logic clockEnableLow,
  input wire logic clockEnableHigh,
  input wire logic [DIV_W-1:0] baudDivisor,
  input wire logic sckSync,
  output logic basicTick,
  output logic sckDrive
);

  logic [DIV_W-1:0] divCnt_q;
  logic sckPrev_q;
  logic running;
  logic useExternal;
  logic divWrap;

  // only the asynchronous mode is served here
  assign running = ~syncMode;
  assign useExternal = clockEnableHigh;
  assign divWrap = (divCnt_q == baudDivisor);

  // internal divider, held at zero when unused
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      divCnt_q <= '0;
    end else if (clkEn) begin
      if (!running || useExternal || divWrap) begin
        divCnt_q <= '0;
      end else begin
        divCnt_q <= DIV_W'(divCnt_q + 1'b1);
      end
    end
  end

  // edge memory of the synchronised external clock
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sckPrev_q <= 1'b1;
    end else if (clkEn) begin
      sckPrev_q <= sckSync;
    end
  end

  // one tick per basic clock period, sixteen per bit either way
  assign basicTick = clkEn & running &
                     (useExternal ? (sckSync & ~sckPrev_q) : divWrap);
  // clock leaves the pin only on the internal source with output enabled
  assign sckDrive = running & ~useExternal & clockEnableLow;

endmodule

// file: test/amc_checker.sv
// concurrent checks on the serial core's ports, bound into every instance
// assumes one clock domain with the asynchronous active-low reset
`timescale 1ns/1ps
module amc_checker (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic txdPin,
  input wire logic sckPinOut,
  input wire logic transmitEnable,
  input wire logic receiveEnable,
  input wire logic receiveFullClear,
  input wire logic transmitIrqEnable,
  input wire logic transmitEndIrqEnable,
  input wire logic receiveIrqEnable,
  input wire logic [7:0] rxData,
  input wire logic addressWaitEnable,
  input wire logic transmitBufferEmpty,
  input wire logic transmitEnd,
  input wire logic receiveFull,
  input wire logic overrunFlag,
  input wire logic framingErrorFlag,
  input wire logic parityErrorFlag,
  input wire logic receivedMultiprocBit,
  input wire logic transmitEmptyRequest,
  input wire logic transmitEndRequest,
  input wire logic receiveFullRequest,
  input wire logic receiveErrorRequest
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////
  // transmitter side
  a_te_forces_empty: assert property (!transmitEnable |=> transmitBufferEmpty)
    else $error("empty flag not forced by disable");
  a_idle_line_high: assert property (!transmitEnable [*3] |-> txdPin)
    else $error("line not idle high");
  a_sck_mid_bit: assert property (
    $rose(sckPinOut) |-> (!transmitEnable || $stable(txdPin)) [*7])
    else $error("output clock edge not at bit centre");
  a_empty_request: assert property (
    transmitEmptyRequest == (transmitIrqEnable && transmitEnable && transmitBufferEmpty))
    else $error("empty request mismatch");
  a_end_request: assert property (
    transmitEndRequest == (transmitEndIrqEnable && transmitEnd))
    else $error("end request mismatch");
  ////////////////////////////////////////
  // receiver side; clears are excluded since they may land while disabled
  a_re_off_keeps: assert property (
    !receiveEnable && !receiveFullClear |=> $stable(receiveFull) && $stable(rxData))
    else $error("disable changed receive state");
  a_overrun_keeps: assert property (
    $rose(overrunFlag) |-> receiveFull && $stable(rxData))
    else $error("overrun lost old data");
  a_full_only_clean: assert property (
    $rose(receiveFull) |-> !framingErrorFlag && !parityErrorFlag && !overrunFlag)
    else $error("full set with error");
  a_rx_requests: assert property (
    receiveErrorRequest == (receiveIrqEnable
      && (overrunFlag || framingErrorFlag || parityErrorFlag))
    && receiveFullRequest == (receiveIrqEnable && receiveFull))
    else $error("receive request mismatch");
  a_wait_end_flag: assert property (
    $fell(addressWaitEnable) |-> receivedMultiprocBit)
    else $error("wait ended without id bit");
  c_overrun: cover property ($rose(overrunFlag));
  c_framing: cover property ($rose(framingErrorFlag));
  c_address: cover property ($fell(addressWaitEnable));
endmodule
bind amc_core amc_checker chk (.*);

// file: test/amc_remote_station.sv
// remote station on the shared line: sends frames, records what it hears
// assumes one bit lasts bitT: 16 clk of 40 ns at divisor 0 unless the bench sets it
`timescale 1ns/1ps
module amc_remote_station (
  input wire logic txd,
  output logic rxd
);
  time bitT = 640ns;
  localparam int N_BITS = 10;
  logic [11:0] got [$];
  time ts [$];
  ////////////////////////////////////////
  // line rests at mark; pull-up level between frames
  initial rxd = 1'h1;
  // low start, then bits from index 0 up, stops supplied by caller
  task automatic send(input logic [11:0] b, input int n);
    rxd = 1'h0;
    #bitT;
    for (int i = 0; i < n; i++) begin
      rxd = b[i];
      #bitT;
    end
    rxd = 1'h1;
  endtask
  // mid-bit sampling; fixed length, so a short frame would swallow an edge
  always begin : hear
    logic [11:0] w;
    @(negedge txd);
    ts.push_back($time);
    w = 12'h000;
    #(bitT / 2);
    for (int i = 0; i < N_BITS; i++) begin
      #bitT;
      w[i] = txd;
    end
    got.push_back(w);
  end
endmodule

// file: test/amc_core_tb_top.sv
// bench for the serial core: control pulses and a remote station on the line
// assumes a tick every clk (divisor 0), so one bit is 16 clk cycles, except in the external clock test at 32
`timescale 1ns/1ps
module amc_core_tb_top;
  logic clk = 1'h0, arst_n = 1'h0, clkEn = 1'h1, sckPinIn = 1'h1, syncMode = 1'h0;
  logic clockEnableLow = 1'h1, clockEnableHigh = 1'h0, characterLength = 1'h0;
  logic parityEnable = 1'h1, parityOdd = 1'h1, multiprocFormatSelect = 1'h0;
  logic stopLength = 1'h0, transmitEnable = 1'h0, receiveEnable = 1'h0;
  logic transmitIrqEnable = 1'h1, transmitEndIrqEnable = 1'h1, receiveIrqEnable = 1'h1;
  logic transmitMultiprocBit = 1'h0, extClk = 1'h0;
  logic [7:0] baudDivisor = 8'h00, txData = 8'h00, rxData;
  logic [5:0] pls = 6'h00;
  logic rxdPin, txdPin, sckPinOut, sckPinOe, addressWaitEnable, transmitBufferEmpty;
  logic transmitEnd, receiveFull, overrunFlag, framingErrorFlag, parityErrorFlag;
  logic receivedMultiprocBit, transmitEmptyRequest, transmitEndRequest;
  logic receiveFullRequest, receiveErrorRequest;
  logic [11:0] rxs;
  int nErrors = 0, nTests = 0;
  assign rxs = {receiveFull, overrunFlag, framingErrorFlag, parityErrorFlag, rxData};
  amc_core uut (.*, .receiveFullClear(pls[0]), .overrunClear(pls[1]),
    .framingErrorClear(pls[2]), .parityErrorClear(pls[3]), .addressWaitSet(pls[4]),
    .txDataWrite(pls[5]));
  amc_remote_station p (.txd(txdPin), .rxd(rxdPin));
  always #20 clk = ~clk;
  // external basic clock: one rising edge every two clk, sixteen per bit
  always @(posedge clk) begin
    if (extClk) begin
      sckPinIn <= ~sckPinIn;
    end
  end
  ////////////////////////////////////////
  // compare, report and count
  task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string m);
    nTests++;
    if (got !== exp) begin
      nErrors++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  // one-cycle control pulse, launched off the edge
  task automatic pulse(input int i);
    @(posedge clk) pls[i] <= 1'h1;
    @(posedge clk) pls[i] <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] d);
    @(posedge clk) txData <= d;
    pls[5] <= 1'h1;
    @(posedge clk) pls[5] <= 1'h0;
    // step off the edge so callers see the flags this write changed
    #1;
  endtask
  // let edge updates land before looking
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic rx(input logic [11:0] b);
    p.send(b, 10);
    settle(8);
  endtask
  task automatic waitEnd();
    for (int k = 0; k < 900 && transmitEnd !== 1'h1; k++) @(posedge clk);
    settle(64);
  endtask
  // 8 data bits, odd parity (optionally wrong), one stop
  function automatic logic [11:0] fr(input logic [7:0] d, input logic bad, input logic st);
    return {2'h0, st, ~^d ^ bad, d};
  endfunction
  task automatic completeRun();
    $display("comparisons %0d mismatches %0d", nTests, nErrors);
    if (nErrors == 0 && nTests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  // watchdog: the sequence needs about 2300 cycles
  initial begin
    repeat (20000) @(posedge clk);
    nErrors++;
    completeRun();
  end
  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    #1;
    chk({txdPin, transmitBufferEmpty, transmitEnd, addressWaitEnable, rxs[11:8], 4'h0},
      12'hE00, "reset values");
    @(posedge clk) arst_n <= 1'h1;
    @(posedge clk) transmitEnable <= 1'h1;
    receiveEnable <= 1'h1;
    wr(8'hA5);
    for (int k = 0; k < 400 && transmitBufferEmpty !== 1'h1; k++) @(posedge clk);
    wr(8'h3C);
    waitEnd();
    chk(p.got[0], fr(8'hA5, 1'h0, 1'h1), "first frame");
    chk(p.got[1], fr(8'h3C, 1'h0, 1'h1), "second frame");
    chk({11'h0, p.ts[1] - p.ts[0] == 11 * p.bitT}, 12'h001, "chained");
    chk({9'h0, sckPinOe, txdPin, transmitEndRequest}, 12'h007, "idle after end");
    $display("transmit test done");
    rx(fr(8'h5A, 1'h0, 1'h1));
    chk(rxs, 12'h85A, "clean frame");
    chk({10'h0, receiveFullRequest, receiveErrorRequest}, 12'h002, "full req");
    rx(fr(8'h11, 1'h0, 1'h1));
    chk(rxs, 12'hC5A, "overrun");
    pulse(1);
    pulse(0);
    rx(fr(8'h22, 1'h1, 1'h1));
    chk(rxs, 12'h122, "parity error");
    pulse(3);
    rx(fr(8'h44, 1'h0, 1'h0));
    chk(rxs, 12'h244, "framing error");
    rx(fr(8'h55, 1'h0, 1'h1));
    chk(rxs, 12'h244, "blocked while errored");
    @(posedge clk) receiveEnable <= 1'h0;
    settle(4);
    chk(rxs, 12'h244, "disable keeps flags");
    pulse(2);
    wr(8'h0F);
    @(posedge clk) transmitEnable <= 1'h0;
    settle(2);
    chk({11'h0, transmitBufferEmpty}, 12'h001, "disable empties");
    $display("receive test done");
    // reformat only while both sides are off
    @(posedge clk) multiprocFormatSelect <= 1'h1;
    characterLength <= 1'h1;
    stopLength <= 1'h1;
    parityOdd <= 1'h0;
    clockEnableLow <= 1'h0;
    @(posedge clk) transmitEnable <= 1'h1;
    receiveEnable <= 1'h1;
    pulse(4);
    rx({2'h0, 2'h3, 1'h0, 7'h77});
    chk({addressWaitEnable, receiveFull, sckPinOe, 2'h0, rxData[6:0]}, 12'h844, "skip data");
    rx({2'h0, 2'h3, 1'h1, 7'h03});
    chk({addressWaitEnable, receiveFull, receivedMultiprocBit, 2'h0, rxData[6:0]},
      12'h603, "id frame taken");
    $display("address wait test done");
    p.got.delete();
    @(posedge clk) transmitMultiprocBit <= 1'h0;
    wr(8'h01);
    waitEnd();
    chk(p.got[0], {2'h0, 2'h3, 1'h0, 7'h01}, "mp data frame");
    $display("multiprocessor transmit test done");
    // external clock runs before the switch and keeps running after it
    @(posedge clk) extClk <= 1'h1;
    transmitEnable <= 1'h0;
    receiveEnable <= 1'h0;
    @(posedge clk) clockEnableHigh <= 1'h1;
    p.bitT = 1280ns;
    p.got.delete();
    @(posedge clk) transmitEnable <= 1'h1;
    wr(8'h5A);
    waitEnd();
    chk(p.got[0], {2'h0, 2'h3, 1'h0, 7'h5A}, "external clock frame");
    chk({11'h0, sckPinOe}, 12'h000, "no clock out on external source");
    $display("external clock test done");
    completeRun();
  end
endmodule
